// ### include/stbsq_map.vh
// stbsq_map.vh: offsets, field positions, reset values, timing counts
// assumes: included by bare name from the top level, the checker and the bench
`ifndef STBSQ_MAP_VH
`define STBSQ_MAP_VH

// ****************************************
// timing
// ****************************************
`define STBSQ_CLK_PERIOD_NS  8
`define STBSQ_MS_IN_NS       1000000
`define STBSQ_MS_CYCLES      (`STBSQ_MS_IN_NS / `STBSQ_CLK_PERIOD_NS)
`define STBSQ_T_LIGHT_MS     5
`define STBSQ_T_DEEP_S       3
`define STBSQ_T_DEEP_MS      (`STBSQ_T_DEEP_S * 1000)
`define STBSQ_MS_CNT_W       17
`define STBSQ_REC_CNT_W      12
`define STBSQ_DLY_W          16

// ****************************************
// register map (byte addresses)
// ****************************************
`define STBSQ_ADDR_W         4
`define STBSQ_OFS_REGEN_DLY  4'h0
`define STBSQ_OFS_STATUS     4'h4
`define STBSQ_REGEN_DLY_RST  16'h0000

// status register fields
`define STBSQ_ST_STATE_LSB   0
`define STBSQ_ST_READY_BIT   4
`define STBSQ_ST_REGEN_BIT   5
`define STBSQ_ST_ACCEPT_BIT  6
`define STBSQ_ST_CODE_LSB    16

// ****************************************
// operating status codes
// ****************************************
`define STBSQ_CODE_W         10
`define STBSQ_CODE_STANDBY   10'd997
`define STBSQ_CODE_REGEN_SB  10'd105
`define STBSQ_CODE_READY     10'd110

// ****************************************
// sequencer states
// ****************************************
`define STBSQ_S_READY        3'h0
`define STBSQ_S_LIGHT        3'h1
`define STBSQ_S_LIGHT_REC    3'h2
`define STBSQ_S_DEEP         3'h3
`define STBSQ_S_DEEP_REC     3'h4

`endif

// ### src/stbsq_sync.v
// stbsq_sync.v: two-flop level synchroniser, one stage pair per bit
// assumes: inputs are levels; glitches shorter than a cycle may still pass
`timescale 1ns/100ps
`default_nettype none

module stbsq_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // levels
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate

endmodule // stbsq_sync

`default_nettype wire

// ### src/stbsq_top.v
// stbsq_top.v: standby sequencer of a drive inverter, AHB-Lite slave
// assumes: one 125 MHz clock, single-word AHB-Lite transfers, a lift
// controller that drives run_permit and the two sleep requests
//
// How it works
// - standby entered only while run permit low
// - light-sleep request enters first standby level
// - light sleep keeps encoder, monitoring, relays on
// - ready 5 ms after light request drops
// - deep sleep powers down encoder, monitoring, relays
// - deep-sleep request enters level two, fault active
// - ready 3 s after deep request, fault active
// - regen enable drops programmable delay after travel
// - zero delay keeps regen enable always on
// - either standby level reports status 997
// - regen unit standby reports status 105 outside either standby level
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "stbsq_map.vh"

module stbsq_top #(
  parameter MS_CYCLES = `STBSQ_MS_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // lift controller side
  input  wire        run_permit,
  input  wire        light_sleep_request,
  input  wire        deep_sleep_request,
  input  wire        travel_active,
  input  wire        fault_present,
  // drive side
  output reg         run_accept,
  output reg         drive_ready,
  output reg         encoder_power_on,
  output reg         monitor_enable,
  output reg         relays_on,
  output reg         fault_indication_output,
  output reg         regen_unit_enable_output,
  output reg  [9:0]  status_code
);

  // ****************************************
  // request synchronisation
  // ****************************************
  wire [1:0] req_sync;

  stbsq_sync #(
    .W        (2)
  ) u_stbsq_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({deep_sleep_request, light_sleep_request}),
    .sync_out (req_sync)
  );

  wire light_req = req_sync[0];
  wire deep_req  = req_sync[1];

  // ****************************************
  // millisecond tick
  // ****************************************
  localparam integer               MS_LAST_I = MS_CYCLES - 1;
  localparam [`STBSQ_MS_CNT_W-1:0] MS_LAST   = MS_LAST_I[`STBSQ_MS_CNT_W-1:0];

  reg [`STBSQ_MS_CNT_W-1:0] ms_cnt_reg;
  reg                       ms_tick_reg;

  // free running; recovery can be up to 1 ms short on the first tick,
  // so the recovery counters take one extra tick to stay on the safe side
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ms_cnt_reg  <= {`STBSQ_MS_CNT_W{1'b0}};
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == MS_LAST) begin
      ms_cnt_reg  <= {`STBSQ_MS_CNT_W{1'b0}};
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg  <= ms_cnt_reg + 1'b1;
      ms_tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  reg [`STBSQ_DLY_W-1:0]  regen_dly_reg;
  reg [`STBSQ_ADDR_W-1:0] wr_addr_reg;
  reg                     wr_pend_reg;
  reg [2:0]               state_reg;
  reg [2:0]               state_next;

  wire access = hsel & hready & htrans[1];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {`STBSQ_ADDR_W{1'b0}};
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      // writes outside the decoded window must not alias onto a register
      wr_pend_reg <= access & hwrite &
                     (haddr[31:`STBSQ_ADDR_W] == 28'h0000000);
      if (access)
        wr_addr_reg <= haddr[`STBSQ_ADDR_W-1:0];
      // read data ready for the data phase: zero wait states
      if (access && !hwrite && haddr[31:`STBSQ_ADDR_W] == 28'h0000000) begin
        case (haddr[`STBSQ_ADDR_W-1:0])
          `STBSQ_OFS_REGEN_DLY:
            hrdata <= {16'h0000, regen_dly_reg};
          `STBSQ_OFS_STATUS: begin
            hrdata <= 32'h00000000;
            hrdata[`STBSQ_ST_STATE_LSB+2:`STBSQ_ST_STATE_LSB] <= state_reg;
            hrdata[`STBSQ_ST_READY_BIT] <= drive_ready;
            hrdata[`STBSQ_ST_REGEN_BIT] <= regen_unit_enable_output;
            hrdata[`STBSQ_ST_ACCEPT_BIT] <= run_accept;
            hrdata[`STBSQ_ST_CODE_LSB+9:`STBSQ_ST_CODE_LSB] <= status_code;
          end
          default:
            hrdata <= 32'h00000000;
        endcase
      end else if (access) begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // write lands in the data phase; status is read only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regen_dly_reg <= `STBSQ_REGEN_DLY_RST;
    end else if (wr_pend_reg && wr_addr_reg == `STBSQ_OFS_REGEN_DLY) begin
      regen_dly_reg <= hwdata[`STBSQ_DLY_W-1:0];
    end
  end

  // ****************************************
  // standby state machine
  // ****************************************
  localparam [`STBSQ_REC_CNT_W-1:0] LIGHT_TICKS = `STBSQ_T_LIGHT_MS;
  localparam [`STBSQ_REC_CNT_W-1:0] DEEP_TICKS  = `STBSQ_T_DEEP_MS;

  reg  [`STBSQ_REC_CNT_W-1:0] rec_cnt_reg;
  wire light_done = ms_tick_reg && (rec_cnt_reg >= LIGHT_TICKS);
  wire deep_done  = ms_tick_reg && (rec_cnt_reg >= DEEP_TICKS);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `STBSQ_S_READY: begin
        if (!run_permit && deep_req)
          state_next = `STBSQ_S_DEEP;
        else if (!run_permit && light_req)
          state_next = `STBSQ_S_LIGHT;
      end
      `STBSQ_S_LIGHT: begin
        if (deep_req)
          state_next = `STBSQ_S_DEEP;
        else if (!light_req)
          state_next = `STBSQ_S_LIGHT_REC;
      end
      `STBSQ_S_LIGHT_REC: begin
        if (deep_req)
          state_next = `STBSQ_S_DEEP;
        else if (light_req)
          state_next = `STBSQ_S_LIGHT;
        else if (light_done)
          state_next = `STBSQ_S_READY;
      end
      `STBSQ_S_DEEP: begin
        if (!deep_req)
          state_next = `STBSQ_S_DEEP_REC;
      end
      `STBSQ_S_DEEP_REC: begin
        if (deep_req)
          state_next = `STBSQ_S_DEEP;
        else if (deep_done)
          state_next = `STBSQ_S_READY;
      end
      default:
        state_next = `STBSQ_S_READY;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= `STBSQ_S_READY;
      rec_cnt_reg <= {`STBSQ_REC_CNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      // recovery time restarts on every entry into a recovery state
      if (state_next != state_reg)
        rec_cnt_reg <= {`STBSQ_REC_CNT_W{1'b0}};
      else if (ms_tick_reg && rec_cnt_reg != {`STBSQ_REC_CNT_W{1'b1}})
        rec_cnt_reg <= rec_cnt_reg + 1'b1;
    end
  end

  // ****************************************
  // regenerative unit standby
  // ****************************************
  reg [`STBSQ_DLY_W-1:0] regen_cnt_reg;
  reg                    regen_count_reg;
  reg                    travel_d_reg;

  wire travel_end = travel_d_reg & ~travel_active;
  wire dly_zero   = (regen_dly_reg == {`STBSQ_DLY_W{1'b0}});
  // unit must be awake again before the next travel needs it
  wire regen_hold = dly_zero | travel_active;
  // one extra tick: the free running tick may come right after travel end
  wire regen_expire = regen_count_reg & ms_tick_reg & ~travel_end &
                      (regen_cnt_reg >= regen_dly_reg);
  // shared with the status code so that both change on one edge
  wire regen_en_next = regen_hold |
                       (regen_unit_enable_output & ~regen_expire);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      travel_d_reg             <= 1'b0;
      regen_cnt_reg            <= {`STBSQ_DLY_W{1'b0}};
      regen_count_reg          <= 1'b0;
      regen_unit_enable_output <= 1'b1;
    end else begin
      travel_d_reg             <= travel_active;
      regen_unit_enable_output <= regen_en_next;
      if (regen_hold) begin
        regen_count_reg <= 1'b0;
        regen_cnt_reg   <= {`STBSQ_DLY_W{1'b0}};
      end else if (travel_end) begin
        regen_count_reg <= 1'b1;
        regen_cnt_reg   <= {`STBSQ_DLY_W{1'b0}};
      end else if (regen_count_reg && ms_tick_reg) begin
        if (regen_expire)
          regen_count_reg <= 1'b0;
        regen_cnt_reg <= regen_cnt_reg + 1'b1;
      end
    end
  end

  // ****************************************
  // outputs per level
  // ****************************************
  wire in_light = (state_next == `STBSQ_S_LIGHT) ||
                  (state_next == `STBSQ_S_LIGHT_REC);
  wire in_deep  = (state_next == `STBSQ_S_DEEP) ||
                  (state_next == `STBSQ_S_DEEP_REC);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_accept              <= 1'b0;
      drive_ready             <= 1'b0;
      encoder_power_on        <= 1'b1;
      monitor_enable          <= 1'b1;
      relays_on               <= 1'b1;
      fault_indication_output <= 1'b1;
      status_code             <= `STBSQ_CODE_READY;
    end else begin
      drive_ready <= (state_next == `STBSQ_S_READY);
      // run permit only counts once recovery is over
      run_accept  <= (state_next == `STBSQ_S_READY) && run_permit;
      // light sleep leaves encoder, monitoring and relays running
      encoder_power_on <= ~in_deep;
      monitor_enable   <= ~in_deep;
      relays_on        <= ~in_deep;
      // fault output held active through deep sleep and its recovery
      if (in_deep)
        fault_indication_output <= 1'b1;
      else
        fault_indication_output <= ~fault_present;
      if (in_light || in_deep)
        status_code <= `STBSQ_CODE_STANDBY;
      else if (!regen_en_next)
        status_code <= `STBSQ_CODE_REGEN_SB;
      else
        status_code <= `STBSQ_CODE_READY;
    end
  end

endmodule // stbsq_top

`default_nettype wire

// ### verification/stbsq_regen_model.sv
// stbsq_regen_model.sv: regenerative feedback unit on the enable line
// assumes: enable comes straight from the sequencer, same clock
`timescale 1ns/100ps
`default_nettype none

module stbsq_regen_model #(
  parameter WAKE_CYCLES = 100
) (
  // clock and reset
  input  wire  clk,
  input  wire  nrst,
  // unit control and state
  input  wire  unit_enable,
  output logic unit_standby,
  output logic unit_ready
);
  // ****
  // wake-up
  // ****
  int wake_cnt;

  // a larger WAKE_CYCLES models a slow unit, still below one second
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt   <= 0;
      unit_ready <= 1'b0;
    end else if (!unit_enable) begin
      wake_cnt   <= 0;
      unit_ready <= 1'b0;
    end else if (wake_cnt < WAKE_CYCLES) begin
      wake_cnt <= wake_cnt + 1;
    end else begin
      unit_ready <= 1'b1;
    end
  end

  assign unit_standby = !unit_enable;
endmodule // stbsq_regen_model
`default_nettype wire

// ### verification/stbsq_top_assertions.sv
// stbsq_top_assertions.sv: port checker of the standby sequencer
// assumes: bound into stbsq_top, which hands on MS_CYCLES
`timescale 1ns/100ps
`default_nettype none
`include "stbsq_map.vh"

module stbsq_chk #(
  parameter MS_CYCLES = 10
) (
  // clock and reset
  input wire       clk,
  input wire       nrst,
  // lift controller side
  input wire       run_permit,
  input wire       light_sleep_request,
  input wire       deep_sleep_request,
  input wire       travel_active,
  input wire       fault_present,
  // drive side
  input wire       run_accept,
  input wire       drive_ready,
  input wire       encoder_power_on,
  input wire       monitor_enable,
  input wire       relays_on,
  input wire       fault_indication_output,
  input wire       regen_unit_enable_output,
  input wire [9:0] status_code
);
  // ****
  // recovery timing
  // ****
  localparam int LT_LO = `STBSQ_T_LIGHT_MS * MS_CYCLES + 2;
  localparam int DP_LO = `STBSQ_T_DEEP_MS * MS_CYCLES + 2;
  int   rec_cnt;
  logic armed;
  logic deep_seen;

  // two sync stages and the state edge land in the count too
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rec_cnt   <= 0;
      armed     <= 1'b0;
      deep_seen <= 1'b0;
    end else begin
      if (light_sleep_request || deep_sleep_request)
        rec_cnt <= 0;
      else if (!drive_ready)
        rec_cnt <= rec_cnt + 1;
      armed     <= !drive_ready &&
                   (armed || status_code == `STBSQ_CODE_STANDBY);
      deep_seen <= !drive_ready && (deep_seen || !relays_on);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_ENTRY_PERMIT: assert property (
    $fell(drive_ready) |-> !$past(run_permit))
    else $error("standby entered with run permit high");
  AST_LIGHT_ENTRY: assert property (
    $rose(light_sleep_request) && drive_ready && !run_permit &&
    !deep_sleep_request ##1
    (light_sleep_request && !run_permit && !deep_sleep_request)[*2]
    |-> ##1 !drive_ready && relays_on && encoder_power_on && monitor_enable)
    else $error("light sleep not entered in time");
  AST_LIGHT_ON: assert property (
    !drive_ready && !deep_seen && !deep_sleep_request &&
    !$past(deep_sleep_request) && !$past(deep_sleep_request, 2) &&
    !$past(deep_sleep_request, 3) |->
    encoder_power_on && monitor_enable && relays_on)
    else $error("light level lost encoder or relays");
  AST_DEEP_OFF: assert property (
    !drive_ready && (deep_seen || !relays_on) |-> !encoder_power_on &&
    !monitor_enable && !relays_on && fault_indication_output)
    else $error("deep level outputs wrong");
  AST_REC_TIME: assert property (
    $rose(drive_ready) && armed |-> (deep_seen ?
    (rec_cnt >= DP_LO && rec_cnt <= DP_LO + MS_CYCLES + 2) :
    (rec_cnt >= LT_LO && rec_cnt <= LT_LO + MS_CYCLES + 2)))
    else $error("recovery time wrong");
  AST_FAULT_FOLLOW: assert property (
    relays_on && $past(nrst) |->
    fault_indication_output == !$past(fault_present))
    else $error("fault output does not follow fault");
  AST_STANDBY_CODE: assert property (
    !drive_ready && $past(nrst) |-> status_code == `STBSQ_CODE_STANDBY)
    else $error("standby code missing");
  AST_REGEN_CODE: assert property (
    drive_ready && !regen_unit_enable_output |->
    status_code == `STBSQ_CODE_REGEN_SB)
    else $error("regen standby code missing");
  AST_TRAVEL_WAKE: assert property (
    travel_active |=> regen_unit_enable_output)
    else $error("regen enable low during travel");
  AST_RUN_GATED: assert property (
    run_accept |-> drive_ready && $past(run_permit))
    else $error("run accepted outside ready");

  COV_DEEP: cover property ($fell(relays_on));
  COV_RECOVER: cover property ($rose(drive_ready) && armed);
  COV_REGEN_SB: cover property ($fell(regen_unit_enable_output));
endmodule // stbsq_chk

bind stbsq_top stbsq_chk #(.MS_CYCLES(MS_CYCLES)) u_stbsq_chk (
  .clk, .nrst, .run_permit, .light_sleep_request, .deep_sleep_request,
  .travel_active, .fault_present, .run_accept, .drive_ready,
  .encoder_power_on, .monitor_enable, .relays_on,
  .fault_indication_output, .regen_unit_enable_output, .status_code
);
`default_nettype wire

// ### verification/stbsq_top_bench.sv
// stbsq_top_bench.sv: self-checking bench of the standby sequencer
// assumes: checker bound in, regen unit model on the enable output
`timescale 1ns/100ps
`default_nettype none
`include "stbsq_map.vh"

module stbsq_top_bench;
  // ****
  // set-up
  // ****
  localparam int MS = 10;
  logic        clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic        run_permit, light_sleep_request, deep_sleep_request;
  logic        travel_active, fault_present, run_accept, drive_ready;
  logic        encoder_power_on, monitor_enable, relays_on, unit_ready;
  logic        fault_indication_output, regen_unit_enable_output;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  status_code;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          error_cnt, num_checks, n, d;
  integer      seed;

  assign hready = hreadyout;
  stbsq_top #(.MS_CYCLES(MS)) u_stbsq_top (
    .clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .run_permit,
    .light_sleep_request, .deep_sleep_request, .travel_active,
    .fault_present, .run_accept, .drive_ready, .encoder_power_on,
    .monitor_enable, .relays_on, .fault_indication_output,
    .regen_unit_enable_output, .status_code);
  stbsq_regen_model u_stbsq_regen_model (
    .clk, .nrst, .unit_enable(regen_unit_enable_output),
    .unit_standby(), .unit_ready);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic int rec_lo(input int m);
    return (m ? `STBSQ_T_DEEP_MS : `STBSQ_T_LIGHT_MS) * MS + 2;
  endfunction

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_r(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: %h, expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wait_rdy(output int cnt);
    cnt = 0;
    while (drive_ready !== 1'b1) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, well past the longest recovery
  initial begin
    repeat (45000) @(posedge clk);
    error_cnt++;
    finish_test;
  end

  initial begin
    seed = 62650;
    nrst = 1'b0;
    hsize = 3'h2;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {light_sleep_request, deep_sleep_request, travel_active} = '0;
    {run_permit, fault_present} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    ahb(1'b1, 32'h8, 32'h5);
    ahb(1'b1, `STBSQ_OFS_STATUS, 32'hFFFF);
    ahb(1'b0, `STBSQ_OFS_REGEN_DLY, '0);
    chk_v(rd, '0);
    ahb(1'b0, 32'h8, '0);
    chk_v(rd, '0);
    ahb(1'b0, `STBSQ_OFS_STATUS, '0);
    chk_v(rd[25:16], `STBSQ_CODE_READY);
    chk_v(hresp, 1'b0);
    $display("register test done");
    // request while permit is still high must be ignored
    run_permit <= 1'b1;
    light_sleep_request <= 1'b1;
    repeat (6) @(posedge clk);
    chk_v(drive_ready, 1'b1);
    light_sleep_request <= 1'b0;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      run_permit <= 1'b0;
      fault_present <= (m == 1);
      @(posedge clk);
      light_sleep_request <= (m == 0);
      deep_sleep_request <= (m == 1);
      repeat (5) @(posedge clk);
      chk_v({drive_ready, encoder_power_on, monitor_enable, relays_on,
        fault_indication_output}, m ? 5'h01 : 5'h0F);
      chk_v(status_code, `STBSQ_CODE_STANDBY);
      {light_sleep_request, deep_sleep_request} <= 2'h0;
      run_permit <= 1'b1;
      repeat (20) @(posedge clk);
      chk_v(run_accept, 1'b0);
      wait_rdy(n);
      chk_r(n + 20, rec_lo(m), rec_lo(m) + MS + 4);
      fault_present <= 1'b0;
      repeat (2) @(posedge clk);
      chk_v({run_accept, fault_indication_output}, 2'h3);
      $display("standby level %0d done", m + 1);
    end
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 0 : 1 + ($random(seed) & 7);
      ahb(1'b1, `STBSQ_OFS_REGEN_DLY, d);
      ahb(1'b0, `STBSQ_OFS_REGEN_DLY, '0);
      chk_v(rd, d);
      travel_active <= 1'b1;
      fault_present <= 1'($random(seed));
      while (unit_ready !== 1'b1) @(posedge clk);
      repeat (3) @(posedge clk);
      travel_active <= 1'b0;
      n = 0;
      while (regen_unit_enable_output === 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk_r(n, d ? d * MS : 200, d ? d * MS + MS + 3 : 200);
      ahb(1'b0, `STBSQ_OFS_STATUS, '0);
      chk_v(rd[25:16], d ? `STBSQ_CODE_REGEN_SB : `STBSQ_CODE_READY);
      $display("regen delay %0d done", d);
    end
    finish_test;
  end
endmodule // stbsq_top_bench
`default_nettype wire
